/* cms_ctrl.sv */
/*
 * cms_ctrl: mode control and status reporting of a CAN controller.
 * Assumes a protocol engine beside it that reports events and role,
 * error counts and its transmit level, all synchronous to clk.
 */
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cms_ctrl #(
	parameter int SLOT_W = 4	// slot number width
) (
	input  wire logic                clk,	// 20 MHz system clock
	input  wire logic                rst_n,	// async reset, active low
	// avalon-mm slave
	input  wire logic [31:0]         avs_address,	// byte address
	input  wire logic                avs_read,	// read request
	input  wire logic                avs_write,	// write request
	input  wire logic [3:0]          avs_byteenable,	// byte lanes
	input  wire logic [31:0]         avs_writedata,	// write data
	output logic      [31:0]         avs_readdata,	// read data
	output logic                     avs_waitrequest,	// stall
	// protocol engine side
	input  wire cms_pkg::cms_evt_s   evt,	// engine events
	input  wire logic                eng_rx_role,	// acting as receiver
	input  wire logic                eng_tx_role,	// acting as transmitter
	input  wire logic                tx_pending,	// some slot holds a send
	input  wire logic                slots_dual_rx,	// slots 14,15 set for data rx
	input  wire logic [8:0]          tec,	// transmit error count
	input  wire logic [7:0]          rec,	// receive error count
	input  wire logic                eng_tx_bit,	// engine transmit level
	input  wire logic                can_rx,	// bus level, 1 recessive
	output logic                     can_tx,	// bus drive, 1 recessive
	output cms_pkg::cms_ctl_s        ctl	// mode controls to engine
);
	import cms_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [15:0]  ctrl_q;	// control word
	logic [15:0]  btim_q;	// clocks per bit minus one
	logic [15:0]  stat;	// assembled status word
	logic         ack_q;	// bus answer cycle
	logic         wr_ctrl;	// control write this edge
	logic         wr_btim;	// bit time write this edge
	logic [15:0]  bcnt_q;	// bit period counter
	logic         bit_tick;	// one pulse per bit time
	logic [3:0]   run_q;	// recessive run length
	logic         idle_ev;	// eleven recessive bits seen
	logic [7:0]   boff_runs_q;	// idle runs during bus-off
	logic         clr_q;	// counter clear pulse
	cms_state_e   st_q;	// mode state
	cms_state_e   st_d;	// next mode state
	logic         bos_q, eps_q, cbs_q, rsb_q, tsb_q, rsc_q, tsc_q;	// flags
	logic [SLOT_W-1:0] msn_q;	// last finished slot
	logic         rst_req, forced_reset_request_req, lb_en, bcm_en, rbo_req;	// control fields

	// decode a byte address to a register, used for reads and writes
	function automatic logic hit(input logic [31:0] a, input logic [31:0] idx);
		return a == {idx[29:0], 2'b00};
	endfunction

	assign rst_req  = ctrl_q[CMS_C_RST];
	assign forced_reset_request_req = ctrl_q[CMS_C_FORCED_RESET_REQUEST];
	assign lb_en    = ctrl_q[CMS_C_LBM];
	assign bcm_en   = ctrl_q[CMS_C_BCM];
	assign rbo_req  = ctrl_q[CMS_C_RBO];

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle, then answer
	// ----------------------------------------------------------------
	// waitrequest drops in the second cycle of every access
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_ctrl = avs_write & ack_q & hit(avs_address, CMS_CTRL_IDX);
	assign wr_btim = avs_write & ack_q & hit(avs_address, CMS_BTIM_IDX);

	// answer strobe, cleared after each completed access
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	// read data captured as the answer cycle starts; unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			if (hit(avs_address, CMS_STAT_IDX)) begin
				avs_readdata <= {16'h0000, stat};
			end else if (hit(avs_address, CMS_CTRL_IDX)) begin
				avs_readdata <= {16'h0000, ctrl_q};
			end else if (hit(avs_address, CMS_BTIM_IDX)) begin
				avs_readdata <= {16'h0000, btim_q};
			end else begin
				avs_readdata <= 32'h0000_0000;
			end
		end
	end

	// control word; status has no write path at all
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= CMS_CTRL_RST;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (wr_ctrl && avs_byteenable[b]) begin
					ctrl_q[b*8 +: 8] <= avs_writedata[b*8 +: 8];
				end
			end
			// recovery request clears itself the clock after it is written; it sits in the upper lane
			if (rbo_req && !(wr_ctrl && avs_byteenable[1])) begin
				ctrl_q[CMS_C_RBO] <= 1'b0;
			end
		end
	end

	// bit time; software should change it only while in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			btim_q <= CMS_BTIM_RST;
		end else begin
			for (int b = 0; b < 2; b++) begin
				if (wr_btim && avs_byteenable[b]) begin
					btim_q[b*8 +: 8] <= avs_writedata[b*8 +: 8];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// bit timing and idle detection
	// ----------------------------------------------------------------
	// free running bit period; the engine does its own fine sync
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bcnt_q <= 16'h0000;
		end else if (bcnt_q >= btim_q) begin
			bcnt_q <= 16'h0000;
		end else begin
			bcnt_q <= bcnt_q + 16'h0001;
		end
	end
	assign bit_tick = (bcnt_q >= btim_q);

	// recessive run; restarts after a full run and on every mode change, so an old run never attaches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 4'h0;
		end else if (bit_tick || st_d != st_q) begin
			if (!can_rx || idle_ev || st_d != st_q) begin
				run_q <= 4'h0;
			end else begin
				run_q <= run_q + 4'h1;
			end
		end
	end
	assign idle_ev = bit_tick && can_rx && (run_q == 4'(CMS_IDLE_BITS - 1));

	// ----------------------------------------------------------------
	// mode state machine
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			CMS_ST_RESET: begin
				// leave only with both requests low
				if (!rst_req && !forced_reset_request_req) begin
					st_d = CMS_ST_CRS_WAIT;
				end
			end
			CMS_ST_CRS_WAIT: begin
				// up to one bit time, to the next bit tick, before reset status drops
				if (rst_req || forced_reset_request_req) begin
					st_d = CMS_ST_RESET;
				end else if (bit_tick) begin
					st_d = CMS_ST_ATTACH;
				end
			end
			CMS_ST_ATTACH: begin
				// join only after a full recessive run
				if (rst_req || forced_reset_request_req) begin
					st_d = CMS_ST_RESET;
				end else if (idle_ev) begin
					st_d = CMS_ST_ON_BUS;
				end
			end
			CMS_ST_ON_BUS: begin
				if (forced_reset_request_req) begin
					st_d = CMS_ST_RESET;
				end else if (tec > 9'(CMS_TEC_BOFF)) begin
					st_d = CMS_ST_BUS_OFF;
				end else if (rst_req) begin
					st_d = CMS_ST_DRAIN;
				end
			end
			CMS_ST_DRAIN: begin
				// pending sends go first, then an idle run
				if (forced_reset_request_req) begin
					st_d = CMS_ST_RESET;
				end else if (tec > 9'(CMS_TEC_BOFF)) begin
					st_d = CMS_ST_BUS_OFF;
				end else if (!tx_pending && idle_ev) begin
					st_d = CMS_ST_RESET;
				end
			end
			CMS_ST_BUS_OFF: begin
				// 128 idle runs, or forced exits
				if (forced_reset_request_req) begin
					st_d = CMS_ST_RESET;
				end else if (rbo_req) begin
					st_d = CMS_ST_ATTACH;
				end else if (idle_ev && boff_runs_q == 8'(CMS_BOFF_RUNS - 1)) begin
					st_d = rst_req ? CMS_ST_RESET : CMS_ST_ON_BUS;
				end
			end
		endcase
	end

	// forced reset lands in one clock, inside the five allowed
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= CMS_ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// idle runs counted only while bus-off
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boff_runs_q <= 8'h00;
		end else if (st_q != CMS_ST_BUS_OFF) begin
			boff_runs_q <= 8'h00;
		end else if (idle_ev) begin
			boff_runs_q <= boff_runs_q + 8'h01;
		end
	end

	// counters zeroed on entry to reset and on bus-off recovery
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clr_q <= 1'b0;
		end else begin
			clr_q <= (st_d == CMS_ST_RESET && st_q != CMS_ST_RESET) ||
				(st_q == CMS_ST_BUS_OFF && st_d != CMS_ST_BUS_OFF);
		end
	end

	// ----------------------------------------------------------------
	// engine controls and bus pin
	// ----------------------------------------------------------------
	always_comb begin
		ctl.attached    = (st_q == CMS_ST_ON_BUS) || (st_q == CMS_ST_DRAIN) ||
			(st_q == CMS_ST_BUS_OFF);
		ctl.engine_rst  = (st_q == CMS_ST_RESET) || (st_q == CMS_ST_CRS_WAIT);
		ctl.ts_run      = (st_q == CMS_ST_ON_BUS) || (st_q == CMS_ST_DRAIN);
		ctl.cnt_clear   = clr_q;
		ctl.accept_own  = lb_en;
		ctl.ack_inhibit = lb_en;
	end

	// detached node keeps the bus recessive
	assign can_tx = (ctl.attached && st_q != CMS_ST_BUS_OFF) ? eng_tx_bit : 1'b1;

	// ----------------------------------------------------------------
	// fault confinement flags
	// ----------------------------------------------------------------
	// bus-off follows the state, so any recovery path clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bos_q <= 1'b0;
		end else begin
			bos_q <= (st_d == CMS_ST_BUS_OFF);
		end
	end

	// error passive only outside bus-off and reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			eps_q <= 1'b0;
		end else begin
			eps_q <= ctl.attached && st_d != CMS_ST_BUS_OFF &&
				(tec > 9'(CMS_EC_PASSIVE) || rec > 8'(CMS_EC_PASSIVE));
		end
	end

	// bus error: the set wins over a completion in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cbs_q <= 1'b0;
		end else if (evt.err) begin
			cbs_q <= 1'b1;
		end else if (evt.tx_done || evt.rx_done) begin
			cbs_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// role and completion flags
	// ----------------------------------------------------------------
	// roles are exclusive; both drop when the engine sits idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsb_q <= 1'b0;
			tsb_q <= 1'b0;
		end else begin
			rsb_q <= ctl.attached && eng_rx_role && !eng_tx_role;
			tsb_q <= ctl.attached && eng_tx_role;
		end
	end

	// receive complete; a looped-back own frame does not count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsc_q <= 1'b0;
		end else if (evt.rx_done) begin
			rsc_q <= 1'b1;
		end else if (evt.tx_done) begin
			rsc_q <= 1'b0;
		end
	end

	// transmit complete; set wins over a same-cycle reception
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tsc_q <= 1'b0;
		end else if (evt.tx_done) begin
			tsc_q <= 1'b1;
		end else if (evt.rx_done) begin
			tsc_q <= 1'b0;
		end
	end

	// last finished slot; no software path clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			msn_q <= '0;
		end else if (evt.tx_done) begin
			msn_q <= evt.tx_slot;	// loopback reports the sender
		end else if (evt.rx_done && evt.stored) begin
			msn_q <= evt.rx_slot;
		end
	end

	// ----------------------------------------------------------------
	// status word; bits 15 and 10 stay zero
	// ----------------------------------------------------------------
	always_comb begin
		stat             = 16'h0000;
		stat[CMS_S_BOS]  = bos_q;
		stat[CMS_S_EPS]  = eps_q;
		stat[CMS_S_CBS]  = cbs_q;
		stat[CMS_S_BCS]  = bcm_en && slots_dual_rx;
		stat[CMS_S_LBS]  = lb_en;
		stat[CMS_S_CRS]  = ctl.engine_rst;
		stat[CMS_S_RSB]  = rsb_q;
		stat[CMS_S_TSB]  = tsb_q;
		stat[CMS_S_RSC]  = rsc_q;
		stat[CMS_S_TSC]  = tsc_q;
		stat[SLOT_W-1:0] = msn_q;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	forced_reset_request_detach_a: assert property (forced_reset_request_req |-> ##[0:4] !ctl.attached)
		else $error("forced reset did not detach in time");
	attach_idle_a: assert property ($rose(ctl.attached) |-> $past(idle_ev))
		else $error("attached without an idle run");
	run_start_a: assert property (ctl.attached |-> !rst_req || !forced_reset_request_req)
		else $error("attached with both resets requested");
	crs_delay_a: assert property ($fell(stat[CMS_S_CRS]) |-> $past(bit_tick) && !rst_req)
		else $error("reset status cleared off the bit tick");
	clear_pulse_a: assert property ($rose(ctl.engine_rst) |-> ctl.cnt_clear)
		else $error("counters not cleared on reset entry");
	loop_tsc_a: assert property (evt.tx_done && evt.self_rx && !evt.rx_done
		|=> tsc_q && !rsc_q && msn_q == $past(evt.tx_slot))
		else $error("loopback completion flags wrong");
	bus_err_a: assert property (evt.err |=> cbs_q)
		else $error("bus error flag not set");
	boff_flag_a: assert property (st_q == CMS_ST_ON_BUS && tec > 9'(CMS_TEC_BOFF) && !forced_reset_request_req
		|=> bos_q)
		else $error("bus-off flag not set");
	rx_tsc_a: assert property (evt.rx_done && !evt.tx_done |=> !tsc_q && rsc_q)
		else $error("reception did not clear transmit complete");
	ack_loop_a: assert property (ctl.ack_inhibit == stat[CMS_S_LBS])
		else $error("ack inhibit out of step with loopback");
	drain_wait_a: assert property (st_q == CMS_ST_DRAIN && tx_pending && !forced_reset_request_req
		&& tec <= 9'(CMS_TEC_BOFF) |=> st_q == CMS_ST_DRAIN)
		else $error("left drain with sends pending");

	cov_attach: cover property ($rose(ctl.attached));
	cov_drain: cover property (st_q == CMS_ST_DRAIN ##1 st_q == CMS_ST_RESET);
	cov_boff: cover property (st_q == CMS_ST_BUS_OFF ##1 st_q != CMS_ST_BUS_OFF);
	cov_loop: cover property (lb_en && evt.tx_done && evt.self_rx);

endmodule // cms_ctrl

/* cms_pkg.sv */
/*
 * cms_pkg: shared constants and carriers for the CAN mode and status block.
 * Assumes a 20 MHz system clock and a word-wide Avalon-MM slave port.
 */
package cms_pkg;

	// ----------------------------------------------------------------
	// register map (printed offsets are word indices)
	// ----------------------------------------------------------------
	localparam logic [31:0] CMS_CTRL_IDX   = 32'h0080_1000;	// mode control word
	localparam logic [31:0] CMS_STAT_IDX   = 32'h0080_1002;	// controller_status
	localparam logic [31:0] CMS_BTIM_IDX   = 32'h0080_1008;	// clocks per bit, minus one

	// control fields, bit 0 is the lsb as in the status word
	localparam int CMS_C_RBO  = 11;	// bus_off_recovery_request (self clearing)
	localparam int CMS_C_FORCED_RESET_REQUEST = 4;	// forced_reset_request
	localparam int CMS_C_BCM  = 3;	// dual_buffer_mode_enable
	localparam int CMS_C_LBM  = 1;	// loopback_enable
	localparam int CMS_C_RST  = 0;	// protocol reset request
	localparam logic [15:0] CMS_CTRL_RST = 16'h0011;	// both resets requested

	// status fields
	localparam int CMS_S_BOS = 14;	// bus_off_flag
	localparam int CMS_S_EPS = 13;	// error_passive_flag
	localparam int CMS_S_CBS = 12;	// bus_error_flag
	localparam int CMS_S_BCS = 11;	// dual_buffer_status_flag
	localparam int CMS_S_LBS = 9;	// loopback_status_flag
	localparam int CMS_S_CRS = 8;	// reset_status_flag
	localparam int CMS_S_RSB = 7;	// receiving_flag
	localparam int CMS_S_TSB = 6;	// transmitting_flag
	localparam int CMS_S_RSC = 5;	// receive_complete_flag
	localparam int CMS_S_TSC = 4;	// transmit_complete_flag
	localparam logic [15:0] CMS_STAT_RST = 16'h0100;	// only reset status set

	// ----------------------------------------------------------------
	// protocol figures and timing
	// ----------------------------------------------------------------
	localparam int CMS_IDLE_BITS   = 11;	// recessive run that marks bus idle
	localparam int CMS_BOFF_RUNS   = 128;	// idle runs to leave bus-off
	localparam int CMS_TEC_BOFF    = 255;	// bus-off above this count
	localparam int CMS_EC_PASSIVE  = 127;	// error passive above this count
	localparam int CMS_FORCED_RESET_REQUEST_MAX    = 5;	// clocks allowed for forced reset
	localparam int CMS_CLK_HZ      = 20_000_000;	// system clock
	localparam int CMS_BITRATE     = 1_000_000;	// default bus rate
	localparam logic [15:0] CMS_BTIM_RST = 16'(CMS_CLK_HZ / CMS_BITRATE - 1);

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       tx_done;	// frame sent normally (pulse)
		logic       rx_done;	// frame received normally (pulse)
		logic       self_rx;	// tx_done frame was taken back in loopback
		logic       stored;	// rx_done frame landed in a slot
		logic       err;	// bus error detected (pulse)
		logic [3:0] tx_slot;	// slot that sent
		logic [3:0] rx_slot;	// slot that stored
	} cms_evt_s;

	typedef struct packed {
		logic attached;	// engine on the bus; may drive and ack except while bus-off
		logic engine_rst;	// hold protocol engine in reset
		logic ts_run;	// timestamp counter may count
		logic cnt_clear;	// zero timestamp and error counters (pulse)
		logic accept_own;	// own frame may be received
		logic ack_inhibit;	// do not ack own frame
	} cms_ctl_s;

	typedef enum logic [2:0] {
		CMS_ST_RESET,	// engine held in reset
		CMS_ST_CRS_WAIT,	// up to one bit time, to the next bit tick, before reset status clears
		CMS_ST_ATTACH,	// waiting for idle run to join the bus
		CMS_ST_ON_BUS,	// communicating
		CMS_ST_DRAIN,	// reset requested, finishing sends
		CMS_ST_BUS_OFF	// bus-off, counting idle runs
	} cms_state_e;

endpackage

/* cms_node.sv */
/* cms_node: the other nodes on the bus, behind the transceiver.
   assumes 1 is recessive on can_tx and can_rx, one system clock. */
`timescale 1ns/1ps
module cms_node (
	input  wire logic clk,	// system clock
	input  wire logic can_tx,	// device drive
	input  wire logic dom,	// bench asks for a dominant bit
	output logic      can_rx	// wired-and bus level
);
	// ------------------------------------------------------------
	// wired-and bus, one clock of transceiver delay
	// ------------------------------------------------------------
	// a released bus goes recessive by its pull-up, never a stale level
	always_ff @(posedge clk) begin
		can_rx <= can_tx & ~dom;
	end
endmodule // cms_node

/* tb_cms_ctrl.sv */
/* tb_cms_ctrl: self-checking bench for cms_ctrl.
   assumes cms_pkg and cms_node; the bench stands in for the protocol engine. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_cms_ctrl;
	import cms_pkg::*;
	localparam logic [31:0] ST = {CMS_STAT_IDX[29:0], 2'b00};	// status byte address
	localparam logic [31:0] CT = {CMS_CTRL_IDX[29:0], 2'b00};	// control byte address
	logic clk = 0, rst_n = 0, rd = 0, wr = 0, dom = 0, can_rx, can_tx, wq;
	logic rxr = 0, txr = 0, txp = 0, dual = 0, etx = 1;
	logic [31:0] adr = '0, wd = '0, rdat;
	logic [8:0] tec = '0;
	logic [7:0] rec = '0;
	logic [15:0] st;
	cms_evt_s evt = '0;
	cms_ctl_s ctl;
	int n_errors = 0, comparisons = 0, cyc = 0, n;
	cms_ctrl cms_ctrl_i (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_byteenable(4'h3), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wq), .evt(evt), .eng_rx_role(rxr), .eng_tx_role(txr),
		.tx_pending(txp), .slots_dual_rx(dual), .tec(tec), .rec(rec), .eng_tx_bit(etx),
		.can_rx(can_rx), .can_tx(can_tx), .ctl(ctl));
	cms_node cms_node_i (.clk(clk), .can_tx(can_tx), .dom(dom), .can_rx(can_rx));
	always #25 clk = ~clk;	// 20 MHz
	// ------------------------------------------------------------
	// watchdog: the bus-off drain alone needs about 28k cycles
	// ------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc > 60000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// avalon cycle: hold until waitrequest is seen low, then release
	task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] d);
		int k;
		k = 0;
		@(posedge clk);
		adr <= a;
		wd <= {16'h0000, d};
		wr <= w;
		rd <= ~w;
		do begin
			@(posedge clk);
			k++;
		end while (wq !== 1'b0 && k < 20);
		st = rdat[15:0];
		`CHK("waitrequest", 1'b0, wq)
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic sb(input int b, input logic v);
		bus(0, ST, 16'h0000);
		`CHK("status_bit", v, st[b])
	endtask
	// clear both resets and wait for the idle run to attach
	task automatic attach();
		bus(1, CT, 16'h0002);	// loopback left as it was
		n = 0;
		while (ctl.attached !== 1'b1 && n < 600) begin
			@(posedge clk);
			n++;
		end
		`CHK("attached", 1'b1, ctl.attached)
		`CHK("idle_run", 1'b1, n >= 11 * 20 - 5)
		`CHK("ts_run", 1'b1, ctl.ts_run)
		sb(CMS_S_CRS, 0);
	endtask
	task automatic ev(input cms_evt_s e, input logic [6:0] x);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= '0;
		bus(0, ST, 16'h0000);
		`CHK("cbs_rsc_tsc_msn", x, {st[CMS_S_CBS], st[CMS_S_RSC], st[CMS_S_TSC], st[3:0]})
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		bus(0, ST, 16'h0000);
		`CHK("status_rst", CMS_STAT_RST, st)
		bus(1, ST, 16'hffff);
		bus(0, ST, 16'h0000);
		`CHK("status_ro", CMS_STAT_RST, st)
		bus(0, CT + 32'h0000_0100, 16'h0000);
		`CHK("unmapped", 16'h0000, st)
		bus(1, CT, 16'h0013);
		sb(CMS_S_LBS, 1);
		`CHK("ack_inhibit", 1'b1, ctl.ack_inhibit)
		`CHK("accept_own", 1'b1, ctl.accept_own)
	endtask
	task automatic t_events();
		ev('{1, 0, 1, 0, 0, 4'h3, 4'h0}, 7'b001_0011);
		ev('{0, 0, 0, 0, 1, 4'h0, 4'h0}, 7'b101_0011);
		ev('{0, 1, 0, 1, 0, 4'h0, 4'h9}, 7'b010_1001);
		ev('{1, 0, 0, 0, 0, 4'hf, 4'h0}, 7'b001_1111);
		ev('{0, 1, 0, 0, 0, 4'h0, 4'h2}, 7'b010_1111);
	endtask
	task automatic t_flags();
		rxr <= 1;
		sb(CMS_S_RSB, 1);
		rxr <= 0;
		txr <= 1;
		sb(CMS_S_RSB, 0);
		sb(CMS_S_TSB, 1);
		txr <= 0;
		sb(CMS_S_TSB, 0);
		tec <= 9'd128;
		sb(CMS_S_EPS, 1);
		tec <= 9'd0;
		rec <= 8'd127;
		sb(CMS_S_EPS, 0);
		dual <= 1;
		bus(1, CT, 16'h000a);
		sb(CMS_S_BCS, 1);
		bus(1, CT, 16'h0002);
		sb(CMS_S_BCS, 0);
	endtask
	task automatic t_forced_reset_request();
		etx <= 0;
		repeat (2) @(posedge clk);
		`CHK("can_tx_on", 1'b0, can_tx)
		bus(1, CT, 16'h0012);
		repeat (2) @(posedge clk);
		`CHK("forced_reset_request_detach", 1'b0, ctl.attached)
		`CHK("forced_reset_request_tx", 1'b1, can_tx)
		`CHK("forced_reset_request_rst", 1'b1, ctl.engine_rst)
		etx <= 1;
	endtask
	task automatic t_drain(input logic boff);
		logic clr;
		clr = 0;
		txp <= ~boff;
		if (boff) tec <= 9'd256;
		if (boff) sb(CMS_S_BOS, 1);
		bus(1, CT, 16'h0003);
		repeat (300) @(posedge clk);
		`CHK("drain_hold", 1'b1, ctl.attached | boff)
		txp <= 0;	// no new send until reset status is back
		n = 0;
		while (ctl.engine_rst !== 1'b1 && n < 40000) begin
			@(posedge clk);
			clr = clr | ctl.cnt_clear;
			n++;
		end
		clr = clr | ctl.cnt_clear;
		`CHK("reset_reached", 1'b1, ctl.engine_rst)
		`CHK("cnt_clear", 1'b1, clr)
		if (boff) `CHK("boff_runs", 1'b1, n >= 128 * 11 * 20 - 400)
		tec <= 9'd0;
		sb(CMS_S_BOS, 0);
		sb(CMS_S_CRS, 1);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		t_regs();
		attach();
		t_events();
		t_flags();
		t_forced_reset_request();
		attach();
		t_drain(0);
		attach();
		t_drain(1);
		tally_and_finish();
	end
endmodule // tb_cms_ctrl
